/* design/mbst_tap.sv */
`include "mbst_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module mbst_tap
  import mbst_pkg::*;
#(
  parameter int          IR_W     = `MBST_IR_W,
  parameter int          ID_W     = `MBST_ID_W,
  parameter int          BSR_W    = `MBST_BSR_W,
  parameter logic [31:0] ID_VALUE = `MBST_ID_VALUE
) (
  input  wire logic             core_clk,    // Memory core clock
  input  wire logic             rst_n,       // Power-up reset, active low
  input  wire logic             tck,         // Test clock from the tester
  input  wire logic             tms,         // Mode select level
  input  wire logic             tms_drv,     // High while tester drives tms
  input  wire logic             tdi,         // Serial data-in level
  input  wire logic             tdi_drv,     // High while tester drives tdi
  input  wire logic [BSR_W-1:0] ring_in,     // Pin levels of the memory ring
  output logic                  tdo,         // Serial data-out
  output logic                  tdo_oe,      // Data-out enable
  output logic      [BSR_W-1:0] ring_out,    // Boundary values for the outputs
  output logic                  core_extest, // Core: outputs show ring_out
  output logic                  core_hiz     // Core: outputs forced inactive
);

  // ------------------------------------------------------------
  // Pin conditioning
  // ------------------------------------------------------------
  // Pull-ups: a floating pin reads as one
  logic tms_eff;
  logic tdi_eff;

  assign tms_eff = tms | ~tms_drv;
  assign tdi_eff = tdi | ~tdi_drv;

  // ------------------------------------------------------------
  // Controller
  // ------------------------------------------------------------
  mbst_state_type state;
  mbst_state_type next_state;

  // Mode select alone steers the walk; five ones reach reset from any state
  always_comb begin
    next_state = state;
    unique case (state)
      MBST_RESET:    next_state = tms_eff ? MBST_RESET   : MBST_IDLE;
      MBST_IDLE:     next_state = tms_eff ? MBST_SEL_DR  : MBST_IDLE;
      MBST_SEL_DR:   next_state = tms_eff ? MBST_SEL_IR  : MBST_CAP_DR;
      MBST_CAP_DR:   next_state = tms_eff ? MBST_EXIT1_DR : MBST_SHIFT_DR;
      MBST_SHIFT_DR: next_state = tms_eff ? MBST_EXIT1_DR : MBST_SHIFT_DR;
      MBST_EXIT1_DR: next_state = tms_eff ? MBST_UPD_DR  : MBST_PAUSE_DR;
      MBST_PAUSE_DR: next_state = tms_eff ? MBST_EXIT2_DR : MBST_PAUSE_DR;
      MBST_EXIT2_DR: next_state = tms_eff ? MBST_UPD_DR  : MBST_SHIFT_DR;
      MBST_UPD_DR:   next_state = tms_eff ? MBST_SEL_DR  : MBST_IDLE;
      MBST_SEL_IR:   next_state = tms_eff ? MBST_RESET   : MBST_CAP_IR;
      MBST_CAP_IR:   next_state = tms_eff ? MBST_EXIT1_IR : MBST_SHIFT_IR;
      MBST_SHIFT_IR: next_state = tms_eff ? MBST_EXIT1_IR : MBST_SHIFT_IR;
      MBST_EXIT1_IR: next_state = tms_eff ? MBST_UPD_IR  : MBST_PAUSE_IR;
      MBST_PAUSE_IR: next_state = tms_eff ? MBST_EXIT2_IR : MBST_PAUSE_IR;
      MBST_EXIT2_IR: next_state = tms_eff ? MBST_UPD_IR  : MBST_SHIFT_IR;
      MBST_UPD_IR:   next_state = tms_eff ? MBST_SEL_DR  : MBST_IDLE;
    endcase
  end

  // Power-up is the only asynchronous path; there is no test reset pin
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      state <= MBST_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ------------------------------------------------------------
  // Instruction register
  // ------------------------------------------------------------
  logic [IR_W-1:0] ir_shift;
  logic [IR_W-1:0] ir_active;
  mbst_instr_type  instr;

  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      ir_shift <= IR_W'(MBST_I_IDCODE);
    end else if (state == MBST_CAP_IR) begin
      ir_shift <= IR_W'(`MBST_IR_CAPTURE);
    end else if (state == MBST_SHIFT_IR) begin
      ir_shift <= {tdi_eff, ir_shift[IR_W-1:1]};
    end
  end

  // Shifting never disturbs the active instruction until update
  // Falling edge latch: a frame that stops in update still takes effect
  always_ff @(negedge tck or negedge rst_n) begin
    if (!rst_n) begin
      ir_active <= IR_W'(MBST_I_IDCODE);
    end else if (state == MBST_RESET) begin
      ir_active <= IR_W'(MBST_I_IDCODE);
    end else if (state == MBST_UPD_IR) begin
      ir_active <= ir_shift;
    end
  end

  assign instr = mbst_instr_type'(ir_active);

  // ------------------------------------------------------------
  // Data register selection
  // ------------------------------------------------------------
  logic sel_id;
  logic sel_bsr;
  logic sel_byp;

  always_comb begin
    sel_id  = 1'b0;
    sel_bsr = 1'b0;
    unique case (instr)
      MBST_I_IDCODE:   sel_id  = 1'b1;
      MBST_I_EXTEST,
      MBST_I_SAMPLE_Z,
      MBST_I_SAMPLE:   sel_bsr = 1'b1;
      MBST_I_RFU3,
      MBST_I_RFU5,
      MBST_I_RFU6,
      MBST_I_BYPASS:   sel_id  = 1'b0;
    endcase
  end

  // Reserved codes fall through to the bypass bit
  assign sel_byp = ~sel_id & ~sel_bsr;

  // ------------------------------------------------------------
  // Bypass, identification and boundary registers
  // ------------------------------------------------------------
  logic             byp;
  logic [ID_W-1:0]  id_shift;
  logic [BSR_W-1:0] bsr_shift;

  // Captures zero so a chain with this port bypassed shows a known lead bit
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      byp <= `MBST_BYPASS_CAP;
    end else if (sel_byp && state == MBST_CAP_DR) begin
      byp <= `MBST_BYPASS_CAP;
    end else if (sel_byp && state == MBST_SHIFT_DR) begin
      byp <= tdi_eff;
    end
  end

  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      id_shift <= '0;
    end else if (sel_id && state == MBST_CAP_DR) begin
      id_shift <= ID_VALUE[ID_W-1:0];
    end else if (sel_id && state == MBST_SHIFT_DR) begin
      id_shift <= {tdi_eff, id_shift[ID_W-1:1]};
    end
  end

  // Ring levels come from the memory clock domain; two test-clock flops
  // settle them, so a capture sees the pins as they stood two edges earlier
  logic [BSR_W-1:0] ring_tck;

  mbst_sync #(
    .W (BSR_W)
  ) u_ring_sync (
    .clk   (tck),
    .rst_n (rst_n),
    .d     (ring_in),
    .q     (ring_tck)
  );

  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      bsr_shift <= '0;
    end else if (sel_bsr && state == MBST_CAP_DR) begin
      bsr_shift <= ring_tck;
    end else if (sel_bsr && state == MBST_SHIFT_DR) begin
      bsr_shift <= {tdi_eff, bsr_shift[BSR_W-1:1]};
    end
  end

  // Parallel output latch moves on the falling edge of update
  // Only boundary instructions move it; it holds through every other frame
  always_ff @(negedge tck or negedge rst_n) begin
    if (!rst_n) begin
      ring_out <= '0;
    end else if (sel_bsr && state == MBST_UPD_DR) begin
      ring_out <= bsr_shift;
    end
  end

  // ------------------------------------------------------------
  // Serial output
  // ------------------------------------------------------------
  logic dr_bit;

  always_comb begin
    if (sel_id) begin
      dr_bit = id_shift[0];
    end else if (sel_bsr) begin
      dr_bit = bsr_shift[0];
    end else begin
      dr_bit = byp;
    end
  end

  always_ff @(negedge tck or negedge rst_n) begin
    if (!rst_n) begin
      tdo <= 1'b0;
    end else begin
      tdo <= (state == MBST_SHIFT_IR) ? ir_shift[0] : dr_bit;
    end
  end

  // The enable trails the state by half a period, so data-out is already
  // settled when the tester samples it on the next rising edge
  always_ff @(negedge tck or negedge rst_n) begin
    if (!rst_n) begin
      tdo_oe <= 1'b0;
    end else begin
      tdo_oe <= (state == MBST_SHIFT_IR) || (state == MBST_SHIFT_DR);
    end
  end

  // ------------------------------------------------------------
  // Mode levels toward the memory core
  // ------------------------------------------------------------
  // Follows the active instruction on the same falling edge, so the levels
  // settle even when the test clock stops right after update
  logic [1:0] mode_tck;
  logic [1:0] next_mode;
  logic [1:0] mode_sync;
  logic [1:0] mode_prev;

  always_comb begin
    next_mode = mode_tck;
    if (state == MBST_RESET) begin
      next_mode = 2'h0;
    end else if (state == MBST_UPD_IR) begin
      next_mode = {ir_shift == IR_W'(MBST_I_SAMPLE_Z), ir_shift == IR_W'(MBST_I_EXTEST)};
    end
  end

  always_ff @(negedge tck or negedge rst_n) begin
    if (!rst_n) begin
      mode_tck <= 2'h0;
    end else begin
      mode_tck <= next_mode;
    end
  end

  // Two-flop crossing into the core clock
  mbst_sync #(
    .W (2)
  ) u_mode_sync (
    .clk   (core_clk),
    .rst_n (rst_n),
    .d     (mode_tck),
    .q     (mode_sync)
  );

  // The two bits may land one core cycle apart; a pair is passed on only
  // once it has read the same twice, which costs one core cycle of latency
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_prev <= 2'h0;
    end else begin
      mode_prev <= mode_sync;
    end
  end

  // Idle port after power-up leaves both levels low
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_extest <= 1'h0;
      core_hiz    <= 1'h0;
    end else if (mode_sync == mode_prev) begin
      core_extest <= mode_sync[0];
      core_hiz    <= mode_sync[1];
    end
  end

endmodule

`default_nettype wire

/* design/mbst_consts.svh */
`ifndef MBST_CONSTS_SVH
`define MBST_CONSTS_SVH

// ------------------------------------------------------------
// Register widths
// ------------------------------------------------------------
`define MBST_IR_W        3
`define MBST_ID_W        32
`define MBST_BSR_W       8

// ------------------------------------------------------------
// Capture and reset values
// ------------------------------------------------------------
`define MBST_IR_CAPTURE  3'h1
`define MBST_BYPASS_CAP  1'h0
// Arbitrary identification value; bit 0 must stay 1
`define MBST_ID_VALUE    32'h0000_0a5f

// ------------------------------------------------------------
// Timing counts
// ------------------------------------------------------------
`define MBST_RESET_EDGES 5

`endif

/* design/mbst_pkg.sv */
package mbst_pkg;

  typedef enum logic [3:0] {
    MBST_RESET      = 4'h0,
    MBST_IDLE       = 4'h1,
    MBST_SEL_DR     = 4'h3,
    MBST_CAP_DR     = 4'h2,
    MBST_SHIFT_DR   = 4'h6,
    MBST_EXIT1_DR   = 4'h7,
    MBST_PAUSE_DR   = 4'h5,
    MBST_EXIT2_DR   = 4'h4,
    MBST_UPD_DR     = 4'hc,
    MBST_SEL_IR     = 4'hd,
    MBST_CAP_IR     = 4'hf,
    MBST_SHIFT_IR   = 4'he,
    MBST_EXIT1_IR   = 4'ha,
    MBST_PAUSE_IR   = 4'hb,
    MBST_EXIT2_IR   = 4'h9,
    MBST_UPD_IR     = 4'h8
  } mbst_state_type;

  typedef enum logic [2:0] {
    MBST_I_EXTEST   = 3'h0,
    MBST_I_IDCODE   = 3'h1,
    MBST_I_SAMPLE_Z = 3'h2,
    MBST_I_RFU3     = 3'h3,
    MBST_I_SAMPLE   = 3'h4,
    MBST_I_RFU5     = 3'h5,
    MBST_I_RFU6     = 3'h6,
    MBST_I_BYPASS   = 3'h7
  } mbst_instr_type;

endpackage

/* design/mbst_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module mbst_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,   // Destination clock
  input  wire logic         rst_n, // Async reset, active low
  input  wire logic [W-1:0] d,     // Level from the other domain
  output logic      [W-1:0] q      // Synchronised level
);

  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

`default_nettype wire

/* testbench/mbst_tap_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module mbst_tap_chk #(
  parameter int          BSR_W    = 8,
  parameter logic [31:0] ID_VALUE = 32'h0 // Arbitrary; bind hands on the real one
) (
  input wire logic             core_clk,    // Core clock
  input wire logic             rst_n,       // Reset
  input wire logic             tck,         // Test clock
  input wire logic             tms,         // Mode select
  input wire logic             tms_drv,     // Driven flag
  input wire logic             tdi,         // Data in
  input wire logic             tdi_drv,     // Driven flag
  input wire logic [BSR_W-1:0] ring_in,     // Ring levels
  input wire logic             tdo,         // Data out
  input wire logic             tdo_oe,      // Out enable
  input wire logic [BSR_W-1:0] ring_out,    // Ring update
  input wire logic             core_extest, // Core mode
  input wire logic             core_hiz     // Core mode
);
  wire logic te = tms | ~tms_drv; // Floating reads high
  default clocking @(posedge tck); endclocking
  default disable iff (!rst_n);
  sequence s_rst; te [*5]; endsequence
  sequence s_dr; s_rst ##1 !te ##1 te ##1 !te [*2]; endsequence
  sequence s_ir; s_rst ##1 !te ##1 te [*2] ##1 !te [*2]; endsequence
  a_reset_oe_off: assert property (s_rst |=> !tdo_oe) else $error("enable after reset");
  a_id_first: assert property (s_dr |=> tdo_oe && tdo == ID_VALUE[0]) else $error("id bit 0");
  a_ir_capture: assert property (s_ir |=> tdo_oe && tdo ##1 !tdo_oe || !tdo) else $error("ir capture");
  a_oe_rise: assert property ($rose(tdo_oe) |-> !$past(te)) else $error("enable rise");
  a_oe_fall: assert property ($fell(tdo_oe) |-> $past(te)) else $error("enable fall");
  a_shift_stay: assert property (tdo_oe && !te |=> tdo_oe) else $error("shift left");
  a_shift_exit: assert property (tdo_oe && te |=> !tdo_oe) else $error("shift kept");
  a_ring_hold: assert property (tdo_oe && $past(tdo_oe) |-> $stable(ring_out)) else $error("ring moved");
endmodule
`default_nettype wire
bind mbst_tap mbst_tap_chk #(
  .BSR_W    (BSR_W),
  .ID_VALUE (ID_VALUE)
) u_chk (
  .core_clk    (core_clk),
  .rst_n       (rst_n),
  .tck         (tck),
  .tms         (tms),
  .tms_drv     (tms_drv),
  .tdi         (tdi),
  .tdi_drv     (tdi_drv),
  .ring_in     (ring_in),
  .tdo         (tdo),
  .tdo_oe      (tdo_oe),
  .ring_out    (ring_out),
  .core_extest (core_extest),
  .core_hiz    (core_hiz)
);

/* testbench/mbst_tester.sv */
`timescale 1ns/1ps
`default_nettype none
module mbst_tester (
  output logic tck,     // Stands low between frames
  output logic tms,     // Mode select
  output logic tms_drv, // Mode select driven
  output logic tdi,     // Data in
  output logic tdi_drv  // Data in driven
);
  initial {tck, tms, tms_drv, tdi, tdi_drv} = 5'h0;
  // A released line toggles, so a stale level never reads as driven
  task automatic step(input logic m, d, md, dd);
    tms_drv = md;
    tdi_drv = dd;
    tms = md ? m : ~tms;
    tdi = dd ? d : ~tdi;
    #3 tck = 1'h1;
    #3 tck = 1'h0;
  endtask
endmodule
`default_nettype wire

/* testbench/test_memory_boundary_scan_tap.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mbst_consts.svh"
module test_memory_boundary_scan_tap;
  import mbst_pkg::*;
  logic        core_clk, rst_n, tck, tms, tms_drv, tdi, tdi_drv, tdo, tdo_oe, core_extest, core_hiz;
  logic [7:0]  ring_in, ring_out;
  logic [39:0] din, fl, de, ex;
  logic        exp_q[$];
  int          err_total, samples_checked, seed;
  mbst_tap DUT (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .tck         (tck),
    .tms         (tms),
    .tms_drv     (tms_drv),
    .tdi         (tdi),
    .tdi_drv     (tdi_drv),
    .ring_in     (ring_in),
    .tdo         (tdo),
    .tdo_oe      (tdo_oe),
    .ring_out    (ring_out),
    .core_extest (core_extest),
    .core_hiz    (core_hiz)
  );
  mbst_tester P (
    .tck     (tck),
    .tms     (tms),
    .tms_drv (tms_drv),
    .tdi     (tdi),
    .tdi_drv (tdi_drv)
  );
  initial begin
    core_clk = 1'h0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic chk(input string n, input logic [39:0] s, e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // An enable with nothing queued is a stray shift state
  always @(posedge tck)
    if (tdo_oe !== 1'h0) begin
      if (exp_q.size() == 0)
        chk("tdo_oe", tdo_oe, 1'h0);
      else
        chk("tdo", tdo, exp_q.pop_front());
    end
  task automatic t(input logic m);
    P.step(m, 1'h0, 1'h1, 1'h1);
  endtask
  // From idle into a shift state, n bits, update, back to idle
  task automatic scan(input logic ir, input int n);
    t(1'h1);
    if (ir)
      t(1'h1);
    t(1'h0);
    t(1'h0);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(ex[i]);
      P.step(i == n - 1, din[i], 1'h1, fl[i]);
    end
    t(1'h1);
    t(1'h0);
  endtask
  task automatic drun(input mbst_instr_type v);
    logic b;
    b = v inside {MBST_I_EXTEST, MBST_I_SAMPLE, MBST_I_SAMPLE_Z};
    din = 40'({$random(seed), $random(seed)});
    fl = 40'({$random(seed), $random(seed)});
    de = din | ~fl;
    @(negedge core_clk);
    ring_in = din[15:8];
    ex = b ? {32'h0, ring_in} : v == MBST_I_IDCODE ? {de[7:0], `MBST_ID_VALUE} : {de[38:0], 1'h0};
    scan(1'h0, b ? 8 : 40);
    repeat (4) @(negedge core_clk);
    if (b)
      chk("ring_out", ring_out, de[7:0]);
    chk("core_extest", core_extest, v == MBST_I_EXTEST);
    chk("core_hiz", core_hiz, v == MBST_I_SAMPLE_Z);
  endtask
  initial begin
    seed = 32'hff0c;
    err_total = 0;
    samples_checked = 0;
    rst_n = 1'h0;
    ring_in = 8'h0;
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'h1;
    repeat (5) P.step(1'h0, 1'h0, 1'h0, 1'h0);
    chk("core_extest", core_extest, 1'h0);
    chk("core_hiz", core_hiz, 1'h0);
    t(1'h0);
    for (int k = 0; k < 8; k++) begin
      din = 40'(k);
      fl = '1;
      ex = 40'h1;
      scan(1'h1, 3);
      drun(mbst_instr_type'(k));
      $display("instruction %0d test done", k);
    end
    // Park in pause-DR, a state that needs the full five ones to reach reset
    t(1'h1);
    t(1'h0);
    t(1'h1);
    t(1'h0);
    repeat (`MBST_RESET_EDGES) t(1'h1);
    t(1'h0);
    drun(MBST_I_IDCODE);
    chk("queue", exp_q.size(), 0);
    $display("reset test done");
    results();
  end
  initial begin
    #50000;
    err_total++;
    results();
  end
endmodule
`default_nettype wire
